// File: bst_params.svh
`ifndef BST_PARAMS_SVH
`define BST_PARAMS_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses are four times the index)
// ---------------------------------------------------------------
`define BST_IDX_TRIM_C 12'h080
`define BST_IDX_TRIM_D 12'h081
`define BST_IDX_OVERLAP 12'h09A
`define BST_IDX_STEER 12'h09B
`define BST_IDX_CTRL 12'h0A0
`define BST_IDX_STATUS 12'h0A1

// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define BST_DLY_MSB 4
`define BST_OVERLAP_RST 5'h08
`define BST_STEER_RST 5'h07
`define BST_OVERLAP_BASE 7'h04
`define BST_CTRL_CAL_EN 0

`endif

// File: bst_pkg.sv
package bst_pkg;
  typedef enum logic [1:0] {BST_IDLE, BST_OVERLAP} bst_state_t;
  typedef struct packed {
    logic [6:0] overlap_len;
    logic [5:0] steer_at;
  } bst_timing_t;
  typedef struct packed {
    logic busy;
    logic core_sel;
    logic steer_sel;
  } bst_swap_out_t;
endpackage : bst_pkg

// File: bst_swap_ctrl.sv
// The APB register port was chosen for this implementation.
`include "bst_params.svh"
`timescale 1ns/10ps
`default_nettype none

module bst_swap_ctrl (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [13:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [7:0] fuse_trim_c_i,
  input wire logic [7:0] fuse_trim_d_i,
  input wire logic swap_req_i,
  output logic [7:0] trim_c_o,
  output logic [7:0] trim_d_o,
  output logic cal_en_o,
  output bst_pkg::bst_swap_out_t swap_o
);
  import bst_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [11:0] word_idx(input logic [13:0] a);
    return a[13:2];
  endfunction : word_idx

  function automatic logic [31:0] zext8(input logic [7:0] v);
    return {24'h000000, v};
  endfunction : zext8

  // ---------------------------------------------------------------
  // apb register file
  // ---------------------------------------------------------------
  logic [7:0] trim_c_q, trim_c_d;
  logic [7:0] trim_d_q, trim_d_d;
  logic [4:0] overlap_q, overlap_d;
  logic [4:0] steer_q, steer_d;
  logic cal_en_q, cal_en_d;
  logic fuse_load_q, fuse_load_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [7:0] fuse_c_s1_q, fuse_c_s2_q, fuse_d_s1_q, fuse_d_s2_q;
  logic req_s1_q, req_s2_q;
  bst_state_t state_q, state_d;
  logic [6:0] cnt_q, cnt_d;
  bst_swap_out_t swap_q, swap_d;

  logic access, wr, hit;
  logic [11:0] idx;

  always_comb begin
    access = psel_i && penable_i && !pready_q;
    // write commits on the edge at which the master samples pready high
    wr = psel_i && penable_i && pready_q && pwrite_i;
    idx = word_idx(paddr_i);
    trim_c_d = trim_c_q;
    trim_d_d = trim_d_q;
    overlap_d = overlap_q;
    steer_d = steer_q;
    cal_en_d = cal_en_q;
    fuse_load_d = 1'b0;
    prdata_d = 32'h00000000;
    pready_d = access;
    pslverr_d = 1'b0;
    hit = 1'b1;
    // trims take the fused value on the cycle after reset release
    if (fuse_load_q) begin
      trim_c_d = fuse_c_s2_q;
      trim_d_d = fuse_d_s2_q;
    end
    case (idx)
      `BST_IDX_TRIM_C: begin
        prdata_d = zext8(trim_c_q);
        if (wr) trim_c_d = pwdata_i[7:0];
      end
      `BST_IDX_TRIM_D: begin
        prdata_d = zext8(trim_d_q);
        if (wr) trim_d_d = pwdata_i[7:0];
      end
      `BST_IDX_OVERLAP: begin
        prdata_d = zext8({3'h0, overlap_q});
        if (wr) overlap_d = pwdata_i[`BST_DLY_MSB:0];
      end
      `BST_IDX_STEER: begin
        prdata_d = zext8({3'h0, steer_q});
        if (wr) steer_d = pwdata_i[`BST_DLY_MSB:0];
      end
      `BST_IDX_CTRL: begin
        prdata_d = {31'h00000000, cal_en_q};
        if (wr) cal_en_d = pwdata_i[`BST_CTRL_CAL_EN];
      end
      `BST_IDX_STATUS: begin
        prdata_d = {29'h00000000, swap_q.busy, swap_q.core_sel, swap_q.steer_sel};
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    if (access && !hit) pslverr_d = 1'b1;
    if (!access) prdata_d = 32'h00000000;
  end

  always_ff @(posedge clk_i) begin
    fuse_c_s1_q <= fuse_trim_c_i;
    fuse_c_s2_q <= fuse_c_s1_q;
    fuse_d_s1_q <= fuse_trim_d_i;
    fuse_d_s2_q <= fuse_d_s1_q;
    req_s1_q <= swap_req_i;
    req_s2_q <= req_s1_q;
    if (!nrst_i) begin
      trim_c_q <= 8'h00;
      trim_d_q <= 8'h00;
      overlap_q <= `BST_OVERLAP_RST;
      steer_q <= `BST_STEER_RST;
      cal_en_q <= 1'b0;
      fuse_load_q <= 1'b1;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      trim_c_q <= trim_c_d;
      trim_d_q <= trim_d_d;
      overlap_q <= overlap_d;
      steer_q <= steer_d;
      cal_en_q <= cal_en_d;
      fuse_load_q <= fuse_load_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ---------------------------------------------------------------
  // swap sequencer
  // ---------------------------------------------------------------
  bst_timing_t tim;
  logic core_cur_q, core_cur_d;

  always_comb begin
    tim.overlap_len = `BST_OVERLAP_BASE + {1'b0, overlap_q, 1'b0};
    tim.steer_at = {1'b0, steer_q};
    state_d = state_q;
    cnt_d = cnt_q;
    core_cur_d = core_cur_q;
    swap_d = swap_q;
    case (state_q)
      BST_IDLE: begin
        swap_d.busy = 1'b0;
        swap_d.core_sel = core_cur_q;
        swap_d.steer_sel = core_cur_q;
        // swaps only start while calibration is enabled
        if (req_s2_q && cal_en_q) begin
          state_d = BST_OVERLAP;
          cnt_d = 7'h00;
          swap_d.busy = 1'b1;
          swap_d.core_sel = !core_cur_q;
        end
      end
      BST_OVERLAP: begin
        cnt_d = cnt_q + 7'h01;
        // steer select moves the programmed delay plus one cycle after overlap start,
        // clamped to the last busy cycle so it never lands outside the swap
        if (cnt_q == {1'b0, tim.steer_at} || cnt_q == tim.overlap_len - 7'h02) begin
          swap_d.steer_sel = !core_cur_q;
        end
        if (cnt_q == tim.overlap_len - 7'h01) begin
          state_d = BST_IDLE;
          swap_d.busy = 1'b0;
          core_cur_d = !core_cur_q;
        end
      end
      default: begin
        state_d = BST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_q <= BST_IDLE;
      cnt_q <= 7'h00;
      core_cur_q <= 1'b0;
      swap_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      core_cur_q <= core_cur_d;
      swap_q <= swap_d;
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign trim_c_o = trim_c_q;
  assign trim_d_o = trim_d_q;
  assign cal_en_o = cal_en_q;
  assign swap_o = swap_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [6:0] busy_cnt_q;
  always_ff @(posedge clk_i) begin
    if (!nrst_i || !swap_q.busy) busy_cnt_q <= 7'h00;
    else busy_cnt_q <= busy_cnt_q + 7'h01;
  end

  overlap_length_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $fell(swap_q.busy) |-> busy_cnt_q == `BST_OVERLAP_BASE + {1'b0, overlap_q, 1'b0})
    else $error("overlap length wrong");
  overlap_reset_a: assert property (@(posedge clk_i)
    !nrst_i |=> overlap_q == `BST_OVERLAP_RST)
    else $error("overlap reset value wrong");
  overlap_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr && idx == `BST_IDX_OVERLAP |=> overlap_q == $past(pwdata_i[4:0]))
    else $error("overlap write lost");
  steer_reset_a: assert property (@(posedge clk_i)
    !nrst_i |=> steer_q == `BST_STEER_RST)
    else $error("steer reset value wrong");
  steer_only_swap_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $changed(swap_q.steer_sel) |-> $past(state_q) == BST_OVERLAP)
    else $error("steer moved outside swap");
  steer_inside_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $changed(swap_q.steer_sel) |-> swap_q.steer_sel == swap_q.core_sel)
    else $error("steer not toward new core");
  trim_c_fuse_a: assert property (@(posedge clk_i)
    !nrst_i ##1 nrst_i |=> trim_c_q == $past(fuse_c_s2_q))
    else $error("trim c not fused");
  trim_d_fuse_a: assert property (@(posedge clk_i)
    !nrst_i ##1 nrst_i |=> trim_d_q == $past(fuse_d_s2_q))
    else $error("trim d not fused");

  // ---------------------------------------------------------------
  // register access checks
  // ---------------------------------------------------------------
  steer_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr && idx == `BST_IDX_STEER |=> steer_q == $past(pwdata_i[`BST_DLY_MSB:0]))
    else $error("steer write lost");
  trim_c_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr && idx == `BST_IDX_TRIM_C |=> trim_c_q == $past(pwdata_i[7:0]))
    else $error("trim c write lost");
  trim_d_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr && idx == `BST_IDX_TRIM_D |=> trim_d_q == $past(pwdata_i[7:0]))
    else $error("trim d write lost");
  cal_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr && idx == `BST_IDX_CTRL |=> cal_en_q == $past(pwdata_i[`BST_CTRL_CAL_EN]))
    else $error("cal enable write lost");
  trim_c_read_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    access && idx == `BST_IDX_TRIM_C |=> prdata_q == {24'h000000, $past(trim_c_q)})
    else $error("trim c read wrong");
  trim_d_read_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    access && idx == `BST_IDX_TRIM_D |=> prdata_q == {24'h000000, $past(trim_d_q)})
    else $error("trim d read wrong");
  overlap_read_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    access && idx == `BST_IDX_OVERLAP |=> prdata_q == {27'h0000000, $past(overlap_q)})
    else $error("overlap read wrong");
  steer_read_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    access && idx == `BST_IDX_STEER |=> prdata_q == {27'h0000000, $past(steer_q)})
    else $error("steer read wrong");
  ready_pulse_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    pready_q |=> !pready_q)
    else $error("ready longer than one cycle");
  unmapped_err_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    access && !hit |=> pslverr_q && prdata_q == 32'h00000000)
    else $error("unmapped access not refused");

  // ---------------------------------------------------------------
  // swap sequencer checks
  // ---------------------------------------------------------------
  swap_start_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_q == BST_IDLE && req_s2_q && cal_en_q |=> swap_q.busy && swap_q.core_sel != $past(core_cur_q))
    else $error("swap did not start");
  swap_gate_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_q == BST_IDLE && !cal_en_q |=> !swap_q.busy)
    else $error("swap started while calibration off");
  steer_time_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_q == BST_OVERLAP && cnt_q == {2'b00, steer_q} |=> swap_q.steer_sel == swap_q.core_sel)
    else $error("steer select late");
  steer_in_swap_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $changed(swap_q.steer_sel) |-> swap_q.busy)
    else $error("steer select moved outside busy");
  overlap_end_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_q == BST_OVERLAP && cnt_q == `BST_OVERLAP_BASE + {1'b0, overlap_q, 1'b0} - 7'h01 |=> !swap_q.busy)
    else $error("overlap did not end");
  cnt_bound_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_q == BST_OVERLAP |-> cnt_q < `BST_OVERLAP_BASE + {1'b0, overlap_q, 1'b0})
    else $error("overlap counter ran past end");

endmodule : bst_swap_ctrl
`default_nettype wire

// File: bst_swap_ctrl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "bst_params.svh"
module bst_swap_ctrl_tb_top;
  import bst_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic swap_req = 1'b0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cal_en;
  logic [7:0] trim_c;
  logic [7:0] trim_d;
  bst_swap_out_t swap;
  int fails = 0;
  int num_checks = 0;

  always #2 clk_i = ~clk_i;

  bst_swap_ctrl i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .fuse_trim_c_i(8'h3C), .fuse_trim_d_i(8'hC3),
    .swap_req_i(swap_req), .trim_c_o(trim_c), .trim_d_o(trim_d), .cal_en_o(cal_en),
    .swap_o(swap));

  // ---------------------------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------------------------
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
           output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask : apb

  task wr(input logic [11:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask : wr

  task rc(input string nm, input logic [11:0] idx, input logic [31:0] exp, input logic xe);
    logic [31:0] d;
    logic e;
    apb(1'b0, idx, 32'h0000_0000, d, e);
    chk(nm, exp, d);
    chk({nm, "_err"}, {31'h0, xe}, {31'h0, e});
  endtask : rc

  // one swap: overlap length and steer moment counted from first busy cycle
  task sw(input int ovl, input int stl);
    int len;
    int at;
    logic cs;
    logic ss;
    wr(`BST_IDX_CTRL, 32'h0000_0000);
    wr(`BST_IDX_OVERLAP, ovl);
    wr(`BST_IDX_STEER, stl);
    wr(`BST_IDX_CTRL, 32'h0000_0001);
    chk("cal_en_o", 32'h0000_0001, {31'h0, cal_en});
    cs = swap.core_sel;
    ss = swap.steer_sel;
    swap_req <= 1'b1;
    while (swap.busy !== 1'b1) begin
      @(posedge clk_i);
    end
    swap_req <= 1'b0;
    chk("core_sel", {31'h0, ~cs}, {31'h0, swap.core_sel});
    len = 0;
    at = -1;
    while (swap.busy === 1'b1 && len < 100) begin
      if (swap.steer_sel !== ss && at < 0) at = len;
      len++;
      @(posedge clk_i);
    end
    chk("overlap_len", 4 + 2 * ovl, len);
    chk("steer_at", (stl + 1 < 4 + 2 * ovl) ? stl + 1 : 3 + 2 * ovl, at);
  endtask : sw

  task final_report;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rc("trim_c", `BST_IDX_TRIM_C, 32'h0000_003C, 1'b0);
    rc("trim_d", `BST_IDX_TRIM_D, 32'h0000_00C3, 1'b0);
    rc("overlap", `BST_IDX_OVERLAP, 32'h0000_0008, 1'b0);
    rc("steer", `BST_IDX_STEER, 32'h0000_0007, 1'b0);
    wr(`BST_IDX_TRIM_C, 32'hFFFF_FFA5);
    rc("trim_c", `BST_IDX_TRIM_C, 32'h0000_00A5, 1'b0);
    chk("trim_c_o", 32'h0000_00A5, {24'h0, trim_c});
    wr(`BST_IDX_TRIM_D, 32'h0000_005A);
    rc("trim_d", `BST_IDX_TRIM_D, 32'h0000_005A, 1'b0);
    chk("trim_d_o", 32'h0000_005A, {24'h0, trim_d});
    wr(`BST_IDX_OVERLAP, 32'h0000_001F);
    rc("overlap", `BST_IDX_OVERLAP, 32'h0000_001F, 1'b0);
    wr(`BST_IDX_STEER, 32'h0000_0015);
    rc("steer", `BST_IDX_STEER, 32'h0000_0015, 1'b0);
    rc("unmapped", 12'h0A2, 32'h0000_0000, 1'b1);
    // request while calibration is off must not start a swap
    swap_req <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("busy_off", 32'h0, {31'h0, swap.busy});
    swap_req <= 1'b0;
    repeat (4) @(posedge clk_i);
    sw(0, 0);
    rc("status", `BST_IDX_STATUS, 32'h0000_0003, 1'b0);
    rc("ctrl", `BST_IDX_CTRL, 32'h0000_0001, 1'b0);
    sw(7, 3);
    sw(31, 31);
    sw(0, 31);
    final_report;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    final_report;
  end
endmodule : bst_swap_ctrl_tb_top
`default_nettype wire
